/* hw/actuator_pkg.sv */
package actuator_pkg;
	typedef logic signed [15:0] pos_t;

	// Attribute identifiers
	localparam logic [7:0] ID_CLASS_REV = 8'h01;
	localparam logic [7:0] ID_SWITCH    = 8'h64;
	localparam logic [7:0] ID_RUN       = 8'h65;
	localparam logic [7:0] ID_TARGET    = 8'h66;
	localparam logic [7:0] ID_MEASURED  = 8'h67;
	localparam logic [7:0] ID_ACHIEVED  = 8'h68;
	localparam logic [7:0] ID_DEADBAND  = 8'h69;
	localparam logic [7:0] ID_HOLD      = 8'h6A;
	localparam logic [7:0] ID_F_RETR    = 8'h6D;
	localparam logic [7:0] ID_F_EXT     = 8'h6E;
	localparam logic [7:0] ID_RETR_END  = 8'h6F;
	localparam logic [7:0] ID_EXT_END   = 8'h70;
	localparam logic [7:0] ID_RETR_SIG  = 8'h71;
	localparam logic [7:0] ID_EXT_SIG   = 8'h72;
	localparam logic [7:0] ID_RETR_THR  = 8'h73;
	localparam logic [7:0] ID_EXT_THR   = 8'h74;
	localparam logic [7:0] ID_SUMMARY   = 8'h75;
	localparam logic [7:0] ID_DEADLOCK  = 8'h76;
	localparam logic [7:0] ID_ILLEGAL   = 8'h78;
	localparam logic [7:0] ID_MEMFAULT  = 8'h79;
	localparam logic [7:0] ID_DL_CLEAR  = 8'h7B;
	localparam logic [7:0] ID_RETRY     = 8'h7C;

	// Ranges in hundredths of a percent, except the retry count minimum
	localparam pos_t POS_MIN   = 16'shFFCE;
	localparam pos_t POS_MAX   = 16'sh2742;
	localparam pos_t EXT_MAX   = 16'sh2710;
	localparam pos_t ZERO_POS  = 16'sh0000;
	localparam pos_t RESOLUTION = 16'sh000A;
	localparam logic [15:0] DB_MIN  = 16'h000A;
	localparam logic [15:0] DB_MAX  = 16'h03E8;
	localparam logic [15:0] DB_STEP = 16'h0014;
	localparam logic [7:0]  RETRY_MIN = 8'h01;

	// Reset values
	localparam pos_t        RETR_END_RST = 16'sh2710;
	localparam pos_t        EXT_END_RST  = 16'sh0000;
	localparam pos_t        RETR_THR_RST = 16'sh2648;
	localparam pos_t        EXT_THR_RST  = 16'sh00C8;
	localparam logic [15:0] DB_RST       = 16'h0032;
	localparam logic [7:0]  HOLD_RST     = 8'h00;
	localparam logic [7:0]  RETRY_RST    = 8'h05;

	// Restart hold timing: one unit is a tenth of a second
	localparam int CLK_PERIOD_NS = 20;
	localparam int HOLD_UNIT_NS  = 100000000;
	localparam int TICK_CYCLES   = HOLD_UNIT_NS / CLK_PERIOD_NS;
	localparam int TICK_W        = 23;

	typedef struct packed {
		logic        get;
		logic        set;
		logic        cls;
		logic [7:0]  id;
		logic [15:0] data;
	} attr_req_t;

	typedef struct packed {
		logic        ack;
		logic        err;
		logic [15:0] data;
	} attr_rsp_t;

	typedef struct packed {
		logic              run;
		pos_t              target;
		logic [15:0]       deadband;
		logic [7:0]        hold_time;
		logic              f_retr;
		logic              f_ext;
		pos_t              retr_end;
		pos_t              ext_end;
		pos_t              retr_thr;
		pos_t              ext_thr;
		logic              clear_dl;
		logic [7:0]        retry;
		logic [7:0]        fail_cnt;
		logic              deadlock;
		logic              illegal;
		logic [7:0]        hold_left;
		logic [TICK_W-1:0] tick;
		pos_t              measured;
		pos_t              setpoint;
		logic              drive;
		logic              achieved;
		logic              retr_sig;
		logic              ext_sig;
		logic              summary;
		attr_rsp_t         rsp;
	} state_t;
endpackage

/* hw/actuator_position_setpoint.sv */
`timescale 1ns/1ns
module actuator_position_setpoint #(
	parameter int              TICK_LEN = actuator_pkg::TICK_CYCLES,
	parameter logic [15:0]     REVISION = 16'h0007
) (
	input  wire logic                   core_clk_i,
	input  wire logic                   srst_i,
	input  wire logic                   ce_i,
	input  wire actuator_pkg::attr_req_t req_i,
	output actuator_pkg::attr_rsp_t     rsp_o,
	input  wire logic                   local_switch_i,
	input  wire actuator_pkg::pos_t     stem_position_i,
	input  wire logic                   memory_fault_i,
	input  wire logic                   start_fail_i,
	input  wire logic                   start_ok_i,
	output actuator_pkg::pos_t          setpoint_o,
	output logic                        drive_enable_o,
	output logic                        position_achieved_o,
	output logic                        retract_end_o,
	output logic                        extend_end_o,
	output logic                        summary_fault_o
);
	import actuator_pkg::*;

	// REVISION value is arbitrary

	// Refuse a tick length that the tick counter cannot reach
	// A short tick only suits simulation; the default gives a true tenth of a second
	if (TICK_LEN < 1 || TICK_LEN > (1 << TICK_W)) begin : g_tick_check
		$error("TICK_LEN out of range");
	end

	// Last tick count of one hold unit
	localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_LEN - 1);

	// All state lives in one struct; s_d is its next value
	state_t s_q;
	state_t s_d;

	// Signed range test used by every settable position
	function automatic logic in_range(input pos_t v, input pos_t lo, input pos_t hi);
		in_range = (v >= lo) && (v <= hi);
	endfunction

	// Deadband quantised to 0.1 + 0.2*n percent, fractions dropped
	function automatic logic [15:0] eff_band(input logic [15:0] db);
		logic [15:0] steps;
		steps = (db - DB_MIN) / DB_STEP;
		eff_band = 16'(steps * DB_STEP) + DB_MIN;
	endfunction

	// Target keeps only 0.1 percent resolution
	function automatic pos_t trunc_res(input pos_t v);
		trunc_res = pos_t'((v / RESOLUTION) * RESOLUTION);
	endfunction

	// Next-state logic. Writes land first so that the setpoint, the
	// deadband test and the end signals all use values written this
	// cycle; the status outputs then follow one edge behind the request.
	always_comb begin
		pos_t        sp;
		logic [15:0] band;
		pos_t        meas;
		logic [16:0] diff;
		logic [17:0] dist2;
		logic        permit;
		logic        ach;
		logic        drv;
		logic        wr;
		logic        bad;
		logic [15:0] rd;
		sp     = 16'sh0000;
		meas   = 16'sh0000;
		diff   = 17'h00000;
		dist2  = 18'h00000;
		permit = 1'b0;
		ach    = 1'b0;
		drv    = 1'b0;
		wr     = 1'b0;
		bad    = 1'b0;
		rd     = 16'h0000;
		band   = 16'h0000;
		s_d    = s_q;

		s_d.rsp.ack = 1'b0;
		s_d.rsp.err = 1'b0;

		// Attribute writes; refused while the switch is on local
		// A set with the class flag or on local is refused, value kept
		wr = req_i.set && !req_i.get && !req_i.cls && !local_switch_i;
		if (req_i.set && !req_i.get) begin
			if (!wr) begin
				bad = 1'b1;
			end else begin
				unique case (req_i.id)
					ID_RUN: s_d.run = req_i.data[0];
					ID_TARGET: begin
						if (in_range(pos_t'(req_i.data), POS_MIN, POS_MAX)) begin
							s_d.target  = trunc_res(pos_t'(req_i.data));
							s_d.illegal = 1'b0;
						end else begin
							// Out of range input is clamped to the nearer limit
							s_d.target  = (pos_t'(req_i.data) < POS_MIN) ? POS_MIN : POS_MAX;
							s_d.illegal = 1'b1;
						end
					end
					ID_DEADBAND: begin
						// An out of range band keeps the old one
						if (req_i.data >= DB_MIN && req_i.data <= DB_MAX) begin
							s_d.deadband = req_i.data;
						end else begin
							bad = 1'b1;
						end
					end
					ID_HOLD: begin
						if (req_i.data[15:8] == 8'h00) begin
							s_d.hold_time = req_i.data[7:0];
						end else begin
							bad = 1'b1;
						end
					end
					// Forced commands are plain bits; priority is settled below
					ID_F_RETR: s_d.f_retr = req_i.data[0];
					ID_F_EXT:  s_d.f_ext  = req_i.data[0];
					// Endpoints and thresholds share the signed range test
					ID_RETR_END: begin
						if (in_range(pos_t'(req_i.data), ZERO_POS, POS_MAX)) begin
							s_d.retr_end = pos_t'(req_i.data);
						end else begin
							bad = 1'b1;
						end
					end
					ID_EXT_END: begin
						if (in_range(pos_t'(req_i.data), POS_MIN, EXT_MAX)) begin
							s_d.ext_end = pos_t'(req_i.data);
						end else begin
							bad = 1'b1;
						end
					end
					ID_RETR_THR: begin
						if (in_range(pos_t'(req_i.data), ZERO_POS, POS_MAX)) begin
							s_d.retr_thr = pos_t'(req_i.data);
						end else begin
							bad = 1'b1;
						end
					end
					ID_EXT_THR: begin
						if (in_range(pos_t'(req_i.data), POS_MIN, EXT_MAX)) begin
							s_d.ext_thr = pos_t'(req_i.data);
						end else begin
							bad = 1'b1;
						end
					end
					// Deadlock clear is a level; it must be written back to 0
					ID_DL_CLEAR: s_d.clear_dl = req_i.data[0];
					// Retry count 1..255; zero would lock at the first failure
					ID_RETRY: begin
						if (req_i.data[15:8] == 8'h00 && req_i.data[7:0] >= RETRY_MIN) begin
							s_d.retry = req_i.data[7:0];
						end else begin
							bad = 1'b1;
						end
					end
					default: bad = 1'b1;
				endcase
			end
		end

		// Attribute reads
		if (req_i.get && !req_i.set) begin
			if (req_i.cls) begin
				// Only the revision attribute exists at class level
				if (req_i.id == ID_CLASS_REV) begin
					rd = REVISION;
				end else begin
					bad = 1'b1;
				end
			end else begin
				unique case (req_i.id)
					ID_SWITCH:    rd = {15'h0000, local_switch_i};
					ID_RUN:       rd = {15'h0000, s_q.run};
					ID_TARGET:    rd = s_q.target;
					ID_MEASURED:  rd = s_q.measured;
					ID_ACHIEVED:  rd = {15'h0000, s_q.achieved};
					ID_DEADBAND:  rd = s_q.deadband;
					ID_HOLD:      rd = {8'h00, s_q.hold_time};
					ID_RETR_END:  rd = s_q.retr_end;
					ID_EXT_END:   rd = s_q.ext_end;
					ID_RETR_SIG:  rd = {15'h0000, s_q.retr_sig};
					ID_EXT_SIG:   rd = {15'h0000, s_q.ext_sig};
					ID_RETR_THR:  rd = s_q.retr_thr;
					ID_EXT_THR:   rd = s_q.ext_thr;
					ID_SUMMARY:   rd = {15'h0000, s_q.summary};
					ID_DEADLOCK:  rd = {15'h0000, s_q.deadlock};
					ID_ILLEGAL:   rd = {15'h0000, s_q.illegal};
					ID_MEMFAULT:  rd = {15'h0000, memory_fault_i};
					ID_DL_CLEAR:  rd = {15'h0000, s_q.clear_dl};
					ID_RETRY:     rd = {8'h00, s_q.retry};
					default:      bad = 1'b1; // Forced commands are write-only
				endcase
			end
		end
		if (req_i.get && req_i.set) begin
			bad = 1'b1;
		end
		// Every request taken while ce_i is high is answered one edge later; a refusal carries zero data
		if (req_i.get || req_i.set) begin
			s_d.rsp.ack  = 1'b1;
			s_d.rsp.err  = bad;
			s_d.rsp.data = bad ? 16'h0000 : rd;
		end

		// Present position, held to the reportable span
		// A sensor value outside the span must not wrap the distance below
		meas = stem_position_i;
		if (meas < POS_MIN) begin
			meas = POS_MIN;
		end
		if (meas > POS_MAX) begin
			meas = POS_MAX;
		end
		s_d.measured = meas;

		// Setpoint selection, retract first
		// Forced commands steer the setpoint even with run at 0; drive stays off
		if (s_d.f_retr) begin
			sp = s_d.retr_end;
		end else if (s_d.f_ext) begin
			sp = s_d.ext_end;
		end else begin
			sp = s_d.target;
		end
		s_d.setpoint = sp;

		// Deadband test: twice the error against the full band width
		// Doubling the error avoids halving an odd band width
		band  = eff_band(s_d.deadband);
		diff  = 17'(signed'({meas[15], meas}) - signed'({sp[15], sp}));
		if (diff[16]) begin
			diff = 17'(-signed'(diff));
		end
		dist2 = {diff, 1'b0};
		ach   = dist2 <= {2'b00, band};
		s_d.achieved = ach;

		// End position signals
		// Strict compares: exactly at its own threshold each signal is off
		s_d.retr_sig = meas > s_d.retr_thr;
		s_d.ext_sig  = meas < s_d.ext_thr;

		// Restart failure counting and deadlock; a held clear wins
		// New failures are ignored while deadlocked, so the count cannot wrap
		if (s_q.clear_dl) begin
			s_d.deadlock = 1'b0;
			s_d.fail_cnt = 8'h00;
		end else if (start_ok_i) begin
			s_d.fail_cnt = 8'h00;
		end else if (start_fail_i && !s_q.deadlock) begin
			if (s_q.fail_cnt + 8'h01 >= s_q.retry) begin
				s_d.deadlock = 1'b1;
				s_d.fail_cnt = 8'h00;
			end else begin
				s_d.fail_cnt = s_q.fail_cnt + 8'h01;
			end
		end

		s_d.summary = s_d.deadlock | s_d.illegal | memory_fault_i;

		// Motion permission
		// Local, memory fault and deadlock each cut the drive at the next edge
		permit = s_d.run && !local_switch_i && !memory_fault_i && !s_d.deadlock;
		drv    = permit && !ach && (s_q.hold_left == 8'h00);

		// Restart hold timer, started on each stop
		// A restart asked for during the hold simply waits for the count to end
		if (s_q.hold_left != 8'h00) begin
			if (s_q.tick == TICK_LAST) begin
				s_d.tick      = '0;
				s_d.hold_left = s_q.hold_left - 8'h01;
			end else begin
				s_d.tick = s_q.tick + TICK_W'(1);
			end
		end else if (s_q.drive && !drv && s_q.hold_time != 8'h00) begin
			s_d.hold_left = s_q.hold_time;
			s_d.tick      = '0;
		end
		s_d.drive = drv;
	end

	// Reset contents: defaults for the settings, zero for the rest
	function automatic state_t reset_state();
		state_t r;
		r           = '0;
		r.deadband  = DB_RST;
		r.hold_time = HOLD_RST;
		r.retr_end  = RETR_END_RST;
		r.ext_end   = EXT_END_RST;
		r.retr_thr  = RETR_THR_RST;
		r.ext_thr   = EXT_THR_RST;
		r.retry     = RETRY_RST;
		reset_state = r;
	endfunction

	// State register with clock enable and synchronous reset
	always_ff @(posedge core_clk_i) begin
		if (srst_i) begin
			s_q <= reset_state();
		end else if (ce_i) begin
			s_q <= s_d;
		end
	end

	assign rsp_o               = s_q.rsp;
	assign setpoint_o          = s_q.setpoint;
	assign drive_enable_o      = s_q.drive;
	assign position_achieved_o = s_q.achieved;
	assign retract_end_o       = s_q.retr_sig;
	assign extend_end_o        = s_q.ext_sig;
	assign summary_fault_o     = s_q.summary;
endmodule

/* testbench/actuator_sva.sv */
`timescale 1ns/1ns
module actuator_sva (
	input wire logic                    core_clk_i,
	input wire logic                    srst_i,
	input wire logic                    ce_i,
	input wire actuator_pkg::attr_req_t req_i,
	input wire actuator_pkg::attr_rsp_t rsp_o,
	input wire logic                    local_switch_i,
	input wire logic                    memory_fault_i,
	input wire logic                    drive_enable_o,
	input wire logic                    position_achieved_o,
	input wire logic                    summary_fault_o
);
	import actuator_pkg::*;
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (srst_i);
	// Decoded instance writes seen by the block
	wire logic wr_c = ce_i & req_i.set & !req_i.get & !req_i.cls;
	wire logic big_c = wr_c & !local_switch_i & (req_i.id == ID_TARGET) & ($signed(req_i.data) > POS_MAX);
	wire logic db_c = wr_c & !local_switch_i & (req_i.id == ID_DEADBAND);

	a_local_refuse: assert property (wr_c && local_switch_i |=> rsp_o.ack && rsp_o.err)
		else $error("write while local not refused");
	a_local_stop: assert property (ce_i && local_switch_i |=> !drive_enable_o)
		else $error("drive while local");
	a_force_wo: assert property (ce_i && req_i.get && !req_i.set && !req_i.cls
		&& (req_i.id == ID_F_RETR || req_i.id == ID_F_EXT) |=> rsp_o.ack && rsp_o.err)
		else $error("forced command readable");
	a_target_clamp: assert property (big_c |=> rsp_o.ack && !rsp_o.err)
		else $error("high target refused");
	a_illegal_sum: assert property (big_c |=> ##[0:1] summary_fault_o)
		else $error("illegal target not flagged");
	a_mem_sum: assert property (ce_i && memory_fault_i |=> summary_fault_o)
		else $error("memory fault missing in summary");
	a_mem_stop: assert property (ce_i && memory_fault_i |=> !drive_enable_o)
		else $error("drive with memory fault");
	a_achieved_stop: assert property (position_achieved_o |-> !drive_enable_o)
		else $error("drive while position achieved");
	a_db_refuse: assert property (db_c && (req_i.data < DB_MIN || req_i.data > DB_MAX) |=> rsp_o.err)
		else $error("deadband out of range accepted");
	a_ce_freeze: assert property (!ce_i |=> $stable(rsp_o) && $stable(drive_enable_o))
		else $error("state moved with clock enable low");
endmodule

bind actuator_position_setpoint actuator_sva u_sva (
	.core_clk_i(core_clk_i), .srst_i(srst_i), .ce_i(ce_i), .req_i(req_i), .rsp_o(rsp_o),
	.local_switch_i(local_switch_i), .memory_fault_i(memory_fault_i), .drive_enable_o(drive_enable_o),
	.position_achieved_o(position_achieved_o), .summary_fault_o(summary_fault_o)
);

/* testbench/dnet_master.sv */
`timescale 1ns/1ns
module dnet_master (
	input  wire logic                    core_clk_i,
	output actuator_pkg::attr_req_t      req_o,
	input  wire actuator_pkg::attr_rsp_t rsp_i
);
	import actuator_pkg::*;
	attr_rsp_t last;
	initial req_o = '0;
	// One transfer: held across the taking edge, answer taken while it stands
	task automatic xfer(input logic wr, input logic c, input logic [7:0] id, input logic [15:0] d);
		@(negedge core_clk_i);
		req_o = '{get: !wr, set: wr, cls: c, id: id, data: d};
		@(negedge core_clk_i);
		last = rsp_i;
		req_o = '{get: 1'b0, set: 1'b0, cls: !c, id: ~id, data: ~d}; // Released lines do not keep old value
	endtask
endmodule

/* testbench/tb_actuator_position_setpoint.sv */
`timescale 1ns/1ns
module tb_actuator_position_setpoint;
	import actuator_pkg::*;
	typedef struct packed {logic [7:0] id; logic [15:0] d; logic e; logic [15:0] r;} row_t;
	logic      core_clk_i = 1'b0;
	logic      srst_i     = 1'b1;
	logic      loc        = 1'b0;
	logic      mem_f      = 1'b0;
	logic      ce         = 1'b1;
	logic      sfail      = 1'b0;
	logic      sok        = 1'b0;
	pos_t      stem       = '0;
	attr_req_t req;
	attr_rsp_t rsp;
	pos_t      sp;
	logic      drv, ach, re, ee, sf;
	int        num_errors = 0;
	int        n_checks   = 0;
	int        cyc        = 0;
	int        k;
	// Write value, error expected, value read back
	row_t rows [11] = '{
		'{ID_DEADBAND, 16'h0009, 1'b1, 16'h0032}, '{ID_DEADBAND, 16'h03E9, 1'b1, 16'h0032},
		'{ID_RETR_END, 16'h2743, 1'b1, 16'h2710}, '{ID_EXT_END, 16'h2711, 1'b1, 16'h0000},
		'{ID_EXT_END, 16'hFFCD, 1'b1, 16'h0000}, '{ID_RETR_THR, 16'hFFFF, 1'b1, 16'h2648},
		'{ID_EXT_THR, 16'h2711, 1'b1, 16'h00C8}, '{ID_HOLD, 16'h0100, 1'b1, 16'h0000},
		'{ID_TARGET, 16'h04D2, 1'b0, 16'h04CE}, '{ID_TARGET, 16'hFFD3, 1'b0, 16'hFFD8},
		'{ID_TARGET, 16'h274C, 1'b0, 16'h2742}};

	always #10 core_clk_i = ~core_clk_i;

	dnet_master m (.core_clk_i(core_clk_i), .req_o(req), .rsp_i(rsp));

	actuator_position_setpoint #(.TICK_LEN(10)) u_dut (
		.core_clk_i(core_clk_i), .srst_i(srst_i), .ce_i(ce), .req_i(req), .rsp_o(rsp),
		.local_switch_i(loc), .stem_position_i(stem), .memory_fault_i(mem_f), .start_fail_i(sfail),
		.start_ok_i(sok), .setpoint_o(sp), .drive_enable_o(drv), .position_achieved_o(ach),
		.retract_end_o(re), .extend_end_o(ee), .summary_fault_o(sf));

	task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("wrong value %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic wr(input logic [7:0] id, input logic [15:0] d, input logic e);
		m.xfer(1'b1, 1'b0, id, d);
		chk("ack", 16'h0001, {15'h0000, m.last.ack});
		chk("err", {15'h0000, e}, {15'h0000, m.last.err});
	endtask

	task automatic rd(input logic [7:0] id, input logic [15:0] exp);
		m.xfer(1'b0, 1'b0, id, 16'h0000);
		chk("read", exp, m.last.data);
	endtask

	task automatic wt(input int n);
		repeat (n) @(negedge core_clk_i);
	endtask

	// One-cycle failed-restart pulses with an idle cycle between them
	task automatic pulse_fail(input int n);
		repeat (n) begin
			sfail = 1'b1;
			wt(1);
			sfail = 1'b0;
			wt(1);
		end
	endtask

	task automatic finish_test();
		$display("checks %0d errors %0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// Cuts a hang short
	always @(posedge core_clk_i) begin
		cyc++;
		if (cyc == 3000) begin
			num_errors++;
			finish_test();
		end
	end

	initial begin
		wt(16);
		srst_i = 1'b0;
		chk("setpoint", 16'h0000, sp);
		chk("drive", 16'h0000, {15'h0000, drv});
		foreach (rows[i]) begin
			wr(rows[i].id, rows[i].d, rows[i].e);
			rd(rows[i].id, rows[i].r);
		end
		rd(ID_ILLEGAL, 16'h0001);
		chk("summary", 16'h0001, {15'h0000, sf});
		wr(ID_TARGET, 16'h1388, 1'b0);
		wr(ID_RUN, 16'h0001, 1'b0);
		wt(2);
		chk("setpoint", 16'h1388, sp);
		chk("drive", 16'h0001, {15'h0000, drv});
		chk("summary", 16'h0000, {15'h0000, sf});
		// Deadband edges around a setpoint of 5000
		stem = 16'sh1374;
		wt(2);
		chk("achieved", 16'h0001, {15'h0000, ach});
		stem = 16'sh136E;
		wt(2);
		chk("achieved", 16'h0000, {15'h0000, ach});
		wr(ID_DEADBAND, 16'h0045, 1'b0);
		wt(2);
		chk("achieved", 16'h0000, {15'h0000, ach});
		wr(ID_DEADBAND, 16'h0046, 1'b0);
		wt(2);
		chk("achieved", 16'h0001, {15'h0000, ach});
		// End signals at both thresholds
		stem = 16'sh2649;
		wt(2);
		chk("retract end", 16'h0001, {15'h0000, re});
		stem = 16'sh2648;
		wt(2);
		chk("retract end", 16'h0000, {15'h0000, re});
		stem = 16'sh00C7;
		wt(2);
		chk("extend end", 16'h0001, {15'h0000, ee});
		stem = 16'sh00C8;
		wt(2);
		chk("extend end", 16'h0000, {15'h0000, ee});
		rd(ID_MEASURED, 16'h00C8);
		// Forced commands and their priority
		wr(ID_F_EXT, 16'h0001, 1'b0);
		wt(2);
		chk("setpoint", 16'h0000, sp);
		wr(ID_F_RETR, 16'h0001, 1'b0);
		wt(2);
		chk("setpoint", 16'h2710, sp);
		m.xfer(1'b0, 1'b0, ID_F_RETR, 16'h0000);
		chk("err", 16'h0001, {15'h0000, m.last.err});
		wr(ID_F_RETR, 16'h0000, 1'b0);
		wr(ID_F_EXT, 16'h0000, 1'b0);
		wt(2);
		chk("setpoint", 16'h1388, sp);
		// Clock enable low freezes state and ignores requests
		ce = 1'b0;
		m.xfer(1'b1, 1'b0, ID_TARGET, 16'h0064);
		chk("ack", 16'h0000, {15'h0000, m.last.ack});
		chk("setpoint", 16'h1388, sp);
		ce = 1'b1;
		rd(ID_TARGET, 16'h1388);
		// Stop, then restart held off by 2 units of 10 cycles
		wr(ID_HOLD, 16'h0002, 1'b0);
		wr(ID_RUN, 16'h0000, 1'b0);
		wt(2);
		chk("drive", 16'h0000, {15'h0000, drv});
		wr(ID_RUN, 16'h0001, 1'b0);
		k = 0;
		while (drv !== 1'b1 && k < 40) begin
			wt(1);
			k++;
		end
		chk("hold", 16'h0001, {15'h0000, k >= 15 && k <= 25});
		// Restart failures: a good start clears the count, the fifth in a row locks
		pulse_fail(4);
		sok = 1'b1;
		wt(1);
		sok = 1'b0;
		pulse_fail(4);
		rd(ID_DEADLOCK, 16'h0000);
		pulse_fail(1);
		rd(ID_DEADLOCK, 16'h0001);
		chk("summary", 16'h0001, {15'h0000, sf});
		chk("drive", 16'h0000, {15'h0000, drv});
		wr(ID_DL_CLEAR, 16'h0001, 1'b0);
		wr(ID_DL_CLEAR, 16'h0000, 1'b0);
		rd(ID_DEADLOCK, 16'h0000);
		chk("summary", 16'h0000, {15'h0000, sf});
		loc = 1'b1;
		wt(2);
		chk("drive", 16'h0000, {15'h0000, drv});
		rd(ID_SWITCH, 16'h0001);
		wr(ID_TARGET, 16'h0000, 1'b1);
		loc = 1'b0;
		mem_f = 1'b1;
		wt(2);
		chk("summary", 16'h0001, {15'h0000, sf});
		chk("drive", 16'h0000, {15'h0000, drv});
		finish_test();
	end
endmodule
